// *** logic/ltpg_regs.svh ***
/*
 * Codes and fixed values of the line test pattern generator.
 * Assumes inclusion by bare name from the design files under logic/.
 */
`ifndef LTPG_REGS_SVH
`define LTPG_REGS_SVH

// ----------------------------------------
// pattern select codes
// ----------------------------------------
`define LTPG_PAT_OFF 3'h0
`define LTPG_PAT_FIXED 3'h1
`define LTPG_PAT_MOVING 3'h2
`define LTPG_PAT_BLACK 3'h3
`define LTPG_PAT_GRAY 3'h4

// ----------------------------------------
// output bit depth codes
// ----------------------------------------
`define LTPG_DEPTH_8 2'h0
`define LTPG_DEPTH_10 2'h1
`define LTPG_DEPTH_12 2'h2

// ----------------------------------------
// pattern values and periods
// ----------------------------------------
`define LTPG_GRAY_8 12'h07f
`define LTPG_GRAY_10 12'h1ff
`define LTPG_GRAY_12 12'h7ff
`define LTPG_BLACK 12'h000
`define LTPG_FIXED_TOP 8'hff
`define LTPG_LINE_PIXELS 4096
`define LTPG_FREE_RUN_CYCLES 5000

`endif

// *** logic/ltpg_pkg.sv ***
/*
 * Types shared by the line test pattern generator modules.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package ltpg_pkg;
   typedef logic [11:0] ltpg_pixel_type;
   typedef logic [1:0] ltpg_depth_type;
   typedef logic [2:0] ltpg_pattern_type;
   typedef enum logic [0:0] {
      LTPG_IDLE = 1'b0,
      LTPG_ACTIVE = 1'b1
   } ltpg_state_type;
endpackage

`default_nettype wire

// *** logic/ltpg_pixel.sv ***
/*
 * Combinational value of one test pattern pixel.
 * Assumes pattern, depth and ramp offset are held steady for the line.
 */
`timescale 1ns/1ps
`include "ltpg_regs.svh"
`default_nettype none

module ltpg_pixel #(
   parameter int IDX_W = 12
) (
   // selection
   input wire ltpg_pkg::ltpg_pattern_type pattern,
   input wire ltpg_pkg::ltpg_depth_type depth,
   // position
   input wire logic [IDX_W-1:0] idx,
   input wire logic [7:0] ramp_ofs,
   // result
   output ltpg_pkg::ltpg_pixel_type value
);

   // ----------------------------------------
   // widening of an 8 bit ramp value
   // ----------------------------------------
   // replicating the top bits lets 8'hff reach the full scale of the depth
   function automatic ltpg_pkg::ltpg_pixel_type scale8(input logic [7:0] v,
                                                       input ltpg_pkg::ltpg_depth_type d);
      unique case (d)
         `LTPG_DEPTH_10: scale8 = {2'h0, v, v[7:6]};
         `LTPG_DEPTH_12: scale8 = {v, v[7:4]};
         default: scale8 = {4'h0, v};
      endcase
   endfunction

   logic [8:0] pos;
   logic [7:0] fixed_v;
   logic [7:0] ramp_v;

   // value depends only on pattern, depth, pixel index and ramp offset
   always_comb begin
      pos = idx[8:0];
      fixed_v = pos[0] ? (`LTPG_FIXED_TOP - pos[8:1]) : pos[8:1];
      ramp_v = idx[7:0] + ramp_ofs;
      unique case (pattern)
         `LTPG_PAT_FIXED: value = scale8(fixed_v, depth);
         `LTPG_PAT_MOVING: value = scale8(ramp_v, depth);
         `LTPG_PAT_GRAY: begin
            unique case (depth)
               `LTPG_DEPTH_10: value = `LTPG_GRAY_10;
               `LTPG_DEPTH_12: value = `LTPG_GRAY_12;
               default: value = `LTPG_GRAY_8;
            endcase
         end
         default: value = `LTPG_BLACK;
      endcase
   end

endmodule // ltpg_pixel

`default_nettype wire

// *** logic/ltpg_top.sv ***
/*
 * Line scan test pattern generator with sensor bypass and shading file store.
 * Assumes all inputs synchronous to CLK; the frame grabber toggles the
 * line trigger in external exposure modes.
 */
// Notes on behaviour
// - one line per external trigger cycle, but at most one trigger is held while a line runs
// - free run: one line per control cycle
// - exposure time never changes pattern values
// - four selectable patterns, off keeps imaging
// - pattern data bypasses sensor path
// - fixed gradient odd pixels count down
// - fixed gradient even pixels count up
// - fixed gradient repeats every 512 pixels
// - gradients span full 10/12 bit range
// - moving ramp repeats every 256 pixels
// - moving ramp start advances per line
// - black pattern is always zero
// - gray is 127, 511 or 2047
// - user upload replaces whole user file
// - factory file readable, never writable
`timescale 1ns/1ps
`include "ltpg_regs.svh"
`default_nettype none

module ltpg_top #(
   parameter int LINE_PIXELS = `LTPG_LINE_PIXELS,
   parameter int FREE_RUN_CYCLES = `LTPG_FREE_RUN_CYCLES,
   parameter int SHD_DEPTH = 64,
   parameter int SHD_AW = 6,
   parameter int SHD_W = 16,
   parameter logic [15:0] FACTORY_WORD = 16'h0100
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // exposure control
   input wire logic EXPOSURE_EXT,
   input wire logic LINE_TRIGGER_INPUT,
   // test image selection
   input wire ltpg_pkg::ltpg_pattern_type PATTERN_SEL,
   input wire ltpg_pkg::ltpg_depth_type BIT_DEPTH,
   // sensor path
   input wire ltpg_pkg::ltpg_pixel_type SENSOR_DATA,
   input wire logic SENSOR_DV,
   input wire logic SENSOR_LV,
   // video output
   output ltpg_pkg::ltpg_pixel_type VIDEO_DATA,
   output logic VIDEO_DV,
   output logic VIDEO_LV,
   // shading file access
   input wire logic SHD_BEGIN,
   input wire logic SHD_WR,
   input wire logic SHD_RD,
   input wire logic SHD_FILE_FACTORY,
   input wire logic [SHD_AW-1:0] SHD_ADDR,
   input wire logic [SHD_W-1:0] SHD_WDATA,
   output logic [SHD_W-1:0] SHD_RDATA,
   output logic SHD_RD_VALID,
   output logic SHD_WR_REJECT
);

   localparam int IDX_W = $clog2(LINE_PIXELS);
   localparam int FR_W = $clog2(FREE_RUN_CYCLES);
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(LINE_PIXELS - 1);
   localparam logic [FR_W-1:0] FR_LAST = FR_W'(FREE_RUN_CYCLES - 1);

   // ----------------------------------------
   // line engine state
   // ----------------------------------------
   ltpg_pkg::ltpg_state_type state_q, state_d;
   logic [IDX_W-1:0] idx_q, idx_d;
   logic [FR_W-1:0] fr_cnt_q, fr_cnt_d;
   logic trig_prev_q, trig_prev_d;
   logic pend_q, pend_d;
   logic [7:0] ofs_q, ofs_d;
   logic [7:0] line_ofs_q, line_ofs_d;
   ltpg_pkg::ltpg_pattern_type pat_prev_q, pat_prev_d;
   ltpg_pkg::ltpg_pattern_type line_pat_q, line_pat_d;
   ltpg_pkg::ltpg_depth_type line_depth_q, line_depth_d;
   ltpg_pkg::ltpg_pixel_type vid_q, vid_d;
   logic dv_q, dv_d;
   logic lv_q, lv_d;

   logic pat_on;
   logic line_event;
   logic start;
   logic [7:0] ofs_base;
   ltpg_pkg::ltpg_pixel_type pix_value;

   ltpg_pixel #(
      .IDX_W(IDX_W)
   ) u_pixel (
      .pattern(line_pat_q),
      .depth(line_depth_q),
      .idx(idx_q),
      .ramp_ofs(line_ofs_q),
      .value(pix_value)
   );

   always_comb begin
      pat_on = (PATTERN_SEL != `LTPG_PAT_OFF);
      trig_prev_d = LINE_TRIGGER_INPUT;
      fr_cnt_d = fr_cnt_q;
      line_event = 1'b0;
      if (EXPOSURE_EXT) begin
         fr_cnt_d = '0;
         line_event = LINE_TRIGGER_INPUT & ~trig_prev_q;
      end else if (fr_cnt_q == FR_LAST) begin
         fr_cnt_d = '0;
         line_event = 1'b1;
      end else begin
         fr_cnt_d = fr_cnt_q + 1'b1;
      end

      // restart the ramp whenever the moving pattern is newly chosen
      pat_prev_d = PATTERN_SEL;
      ofs_base = ofs_q;
      if (PATTERN_SEL == `LTPG_PAT_MOVING && pat_prev_q != `LTPG_PAT_MOVING) begin
         ofs_base = 8'h00;
      end

      state_d = state_q;
      idx_d = idx_q;
      pend_d = pend_q;
      start = 1'b0;
      unique case (state_q)
         ltpg_pkg::LTPG_IDLE: begin
            if (pat_on && (line_event || pend_q)) begin
               start = 1'b1;
            end
         end
         ltpg_pkg::LTPG_ACTIVE: begin
            // a trigger during a line is kept as one pending start; a second one in the same line is lost
            if (line_event) begin
               pend_d = 1'b1;
            end
            if (idx_q == LAST_IDX) begin
               state_d = ltpg_pkg::LTPG_IDLE;
               if (pat_on && (line_event || pend_q)) begin
                  start = 1'b1;
               end
            end else begin
               idx_d = idx_q + 1'b1;
            end
         end
      endcase
      if (!pat_on) begin
         pend_d = 1'b0;
      end

      line_pat_d = line_pat_q;
      line_depth_d = line_depth_q;
      line_ofs_d = line_ofs_q;
      ofs_d = ofs_base;
      if (start) begin
         state_d = ltpg_pkg::LTPG_ACTIVE;
         idx_d = '0;
         pend_d = 1'b0;
         line_pat_d = PATTERN_SEL;
         line_depth_d = BIT_DEPTH;
         line_ofs_d = ofs_base;
         if (PATTERN_SEL == `LTPG_PAT_MOVING) begin
            ofs_d = ofs_base + 8'h01;
         end
      end

      // test data replaces the sensor stream outright while a pattern is on
      if (pat_on || state_q == ltpg_pkg::LTPG_ACTIVE) begin
         vid_d = (state_q == ltpg_pkg::LTPG_ACTIVE) ? pix_value : `LTPG_BLACK;
         dv_d = (state_q == ltpg_pkg::LTPG_ACTIVE);
         lv_d = (state_q == ltpg_pkg::LTPG_ACTIVE);
      end else begin
         vid_d = SENSOR_DATA;
         dv_d = SENSOR_DV;
         lv_d = SENSOR_LV;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= ltpg_pkg::LTPG_IDLE;
         idx_q <= '0;
         fr_cnt_q <= '0;
         trig_prev_q <= 1'b0;
         pend_q <= 1'b0;
         ofs_q <= 8'h00;
         line_ofs_q <= 8'h00;
         pat_prev_q <= `LTPG_PAT_OFF;
         line_pat_q <= `LTPG_PAT_OFF;
         line_depth_q <= `LTPG_DEPTH_8;
         vid_q <= 12'h000;
         dv_q <= 1'b0;
         lv_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         fr_cnt_q <= fr_cnt_d;
         trig_prev_q <= trig_prev_d;
         pend_q <= pend_d;
         ofs_q <= ofs_d;
         line_ofs_q <= line_ofs_d;
         pat_prev_q <= pat_prev_d;
         line_pat_q <= line_pat_d;
         line_depth_q <= line_depth_d;
         vid_q <= vid_d;
         dv_q <= dv_d;
         lv_q <= lv_d;
      end
   end

   assign VIDEO_DATA = vid_q;
   assign VIDEO_DV = dv_q;
   assign VIDEO_LV = lv_q;

   // ----------------------------------------
   // shading file store
   // ----------------------------------------
   // words not written since the last upload start read as zero, so an
   // upload never mixes with the old file without a full-array clear
   logic [SHD_W-1:0] user_mem [SHD_DEPTH];
   logic [SHD_DEPTH-1:0] vld_q, vld_d;
   logic [SHD_W-1:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic reject_q, reject_d;
   logic mem_we;

   always_comb begin
      vld_d = vld_q;
      mem_we = 1'b0;
      reject_d = 1'b0;
      if (SHD_FILE_FACTORY) begin
         reject_d = SHD_WR | SHD_BEGIN;
      end else begin
         if (SHD_BEGIN) begin
            vld_d = '0;
         end
         if (SHD_WR) begin
            mem_we = 1'b1;
            vld_d[SHD_ADDR] = 1'b1;
         end
      end
      rvalid_d = SHD_RD;
      rdata_d = rdata_q;
      if (SHD_RD) begin
         if (SHD_FILE_FACTORY) begin
            rdata_d = SHD_W'(FACTORY_WORD);
         end else begin
            rdata_d = vld_q[SHD_ADDR] ? user_mem[SHD_ADDR] : '0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (mem_we) begin
         user_mem[SHD_ADDR] <= SHD_WDATA;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         vld_q <= '0;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         vld_q <= vld_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         reject_q <= reject_d;
      end
   end

   assign SHD_RDATA = rdata_q;
   assign SHD_RD_VALID = rvalid_q;
   assign SHD_WR_REJECT = reject_q;

endmodule // ltpg_top

`default_nettype wire

// *** dv/ltpg_assertions.sv ***
/* checker on the ltpg_top ports, bound after the module
   assumes selections held steady over each line */
`timescale 1ns/1ps
`default_nettype none
module ltpg_checker #(parameter int LINE_PIXELS = 16) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // selection
   input wire ltpg_pkg::ltpg_pattern_type PATTERN_SEL,
   input wire ltpg_pkg::ltpg_depth_type BIT_DEPTH,
   // video
   input wire ltpg_pkg::ltpg_pixel_type VIDEO_DATA,
   input wire logic VIDEO_DV,
   input wire logic VIDEO_LV,
   // shading
   input wire logic SHD_BEGIN,
   input wire logic SHD_WR,
   input wire logic SHD_RD,
   input wire logic SHD_FILE_FACTORY,
   input wire logic SHD_RD_VALID,
   input wire logic SHD_WR_REJECT
);
   ltpg_pkg::ltpg_pattern_type pat_q;
   ltpg_pkg::ltpg_depth_type dep_q;
   logic [11:0] idx_q;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // selection frozen while a line shows; index of the pixel on show
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pat_q <= 3'h0;
         dep_q <= 2'h0;
         idx_q <= 12'h000;
      end else begin
         pat_q <= VIDEO_LV ? pat_q : PATTERN_SEL;
         dep_q <= VIDEO_LV ? dep_q : BIT_DEPTH;
         idx_q <= (!VIDEO_DV || idx_q == 12'(LINE_PIXELS - 1)) ? 12'h000 : idx_q + 12'h001;
      end
   end
   sequence s_end;
      VIDEO_LV ##1 !VIDEO_LV && pat_q != 3'h0;
   endsequence
   chk_line_len:
   assert property (s_end |-> idx_q == 12'h000) else $error("line length wrong");
   chk_fixed_8bit:
   assert property (VIDEO_DV && pat_q == 3'h1 && dep_q == 2'h0
      |-> VIDEO_DATA == {4'h0, idx_q[0] ? 8'hff - idx_q[8:1] : idx_q[8:1]})
      else $error("fixed ramp wrong");
   chk_fixed_deep:
   assert property (VIDEO_DV && pat_q == 3'h1 && dep_q != 2'h0 && idx_q == 12'h001
      |-> VIDEO_DATA == (dep_q == 2'h2 ? 12'hfff : 12'h3ff)) else $error("ramp top wrong");
   chk_moving_step:
   assert property (VIDEO_DV && idx_q != 12'h000 && pat_q == 3'h2 && dep_q == 2'h0
      |-> VIDEO_DATA[7:0] == $past(VIDEO_DATA[7:0]) + 8'h01) else $error("ramp step wrong");
   chk_black_zero:
   assert property (VIDEO_DV && pat_q == 3'h3 |-> VIDEO_DATA == 12'h000)
      else $error("black not zero");
   chk_gray_level:
   assert property (VIDEO_DV && pat_q == 3'h4 |-> VIDEO_DATA ==
      (dep_q == 2'h0 ? 12'h07f : dep_q == 2'h1 ? 12'h1ff : 12'h7ff)) else $error("gray wrong");
   chk_fac_reject:
   assert property ((SHD_WR || SHD_BEGIN) && SHD_FILE_FACTORY |=> SHD_WR_REJECT)
      else $error("factory write not refused");
   chk_user_accept:
   assert property ((SHD_WR || SHD_BEGIN) && !SHD_FILE_FACTORY |=> !SHD_WR_REJECT)
      else $error("user write refused");
   chk_rd_answer:
   assert property (SHD_RD |=> SHD_RD_VALID) else $error("read not answered");
   chk_lv_dv_pair:
   assert property ($past(PATTERN_SEL) != 3'h0 |-> VIDEO_LV == VIDEO_DV)
      else $error("line and data valid differ");
endmodule // ltpg_checker
bind ltpg_top ltpg_checker #(.LINE_PIXELS(LINE_PIXELS)) ltpg_checker_inst (
   .CLK(CLK), .RST_B(RST_B), .PATTERN_SEL(PATTERN_SEL), .BIT_DEPTH(BIT_DEPTH),
   .VIDEO_DATA(VIDEO_DATA), .VIDEO_DV(VIDEO_DV), .VIDEO_LV(VIDEO_LV), .SHD_BEGIN(SHD_BEGIN),
   .SHD_WR(SHD_WR), .SHD_RD(SHD_RD), .SHD_FILE_FACTORY(SHD_FILE_FACTORY),
   .SHD_RD_VALID(SHD_RD_VALID), .SHD_WR_REJECT(SHD_WR_REJECT));
`default_nettype wire

// *** dv/ltpg_grabber.sv ***
/* frame grabber model: toggles the line trigger, gathers video lines
   assumes one pixel per clock while data valid is high */
`timescale 1ns/1ps
`default_nettype none
module ltpg_grabber #(parameter int LINE_PIXELS = 16) (
   // clock
   input wire logic clk,
   // video from the camera
   input wire ltpg_pkg::ltpg_pixel_type vdat,
   input wire logic vdv,
   // line trigger to the camera
   output logic trig
);
   ltpg_pkg::ltpg_pixel_type pix [LINE_PIXELS];
   int n = 0;
   int lines = 0;
   initial trig = 1'b0;
   // one trigger cycle; hi and lo set how promptly the grabber toggles
   task pulse(input int hi, input int lo);
      @(negedge clk);
      trig = 1'b1;
      repeat (hi) @(negedge clk);
      trig = 1'b0;
      repeat (lo) @(negedge clk);
   endtask
   // a gap in data valid restarts the count, so stray sensor pixels do no harm
   always @(posedge clk) begin
      if (vdv !== 1'b1) n <= 0;
      else begin
         pix[n] <= vdat;
         n <= (n == LINE_PIXELS - 1) ? 0 : n + 1;
         if (n == LINE_PIXELS - 1) lines <= lines + 1;
      end
   end
endmodule // ltpg_grabber
`default_nettype wire

// *** dv/test_line_camera_test_pattern_gen.sv ***
/* bench: random trigger timing and sensor noise against the four patterns
   assumes ltpg_top, the bound checker and the grabber model */
`timescale 1ns/1ps
`default_nettype none
module test_line_camera_test_pattern_gen;
   localparam int LP = 520;
   localparam int FR = 700;
   localparam logic [15:0] FW = 16'h0100;
   logic clk = 1'b0, rst_b = 1'b0, ext = 1'b1, trig, vdv, vlv, srv, srej;
   logic [2:0] sel = 3'h0;
   logic [1:0] dep = 2'h0;
   logic [11:0] sdat = 12'h000, vdat;
   logic sdv = 1'b0, slv = 1'b0, sbeg = 1'b0, swr = 1'b0, srd = 1'b0, sfac = 1'b0;
   logic [5:0] sa = 6'h00;
   logic [15:0] swd = 16'h0000, rdat, wd;
   int mismatches = 0, tests_run = 0, cyc = 0, mofs = 0, l0, t0;
   ltpg_top #(.LINE_PIXELS(LP), .FREE_RUN_CYCLES(FR), .FACTORY_WORD(FW)) ltpg_top_inst (
      .CLK(clk), .RST_B(rst_b), .EXPOSURE_EXT(ext), .LINE_TRIGGER_INPUT(trig),
      .PATTERN_SEL(sel), .BIT_DEPTH(dep), .SENSOR_DATA(sdat), .SENSOR_DV(sdv),
      .SENSOR_LV(slv), .VIDEO_DATA(vdat), .VIDEO_DV(vdv), .VIDEO_LV(vlv), .SHD_BEGIN(sbeg),
      .SHD_WR(swr), .SHD_RD(srd), .SHD_FILE_FACTORY(sfac), .SHD_ADDR(sa), .SHD_WDATA(swd),
      .SHD_RDATA(rdat), .SHD_RD_VALID(srv), .SHD_WR_REJECT(srej));
   ltpg_grabber #(.LINE_PIXELS(LP)) ltpg_grabber_inst (.clk(clk), .vdat(vdat), .vdv(vdv),
      .trig(trig));
   initial forever #20 clk = ~clk;
   always @(negedge clk) cyc++;
   // sensor noise must never reach a pattern line, but passes while patterns are off
   always @(negedge clk) begin
      sdat <= 12'($urandom);
      sdv <= 1'($urandom);
      slv <= 1'($urandom);
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function logic [11:0] expv(input logic [2:0] p, input logic [1:0] d, input int i, input int o);
      logic [7:0] v;
      if (p == 3'h3) return 12'h000;
      if (p == 3'h4) return d == 2'h0 ? 12'h07f : d == 2'h1 ? 12'h1ff : 12'h7ff;
      v = p == 3'h2 ? 8'(i + o) : i % 2 ? 8'hff - 8'((i % 512) / 2) : 8'((i % 512) / 2);
      return d == 2'h0 ? {4'h0, v} : d == 2'h1 ? {2'h0, v, v[7:6]} : {v, v[7:4]};
   endfunction
   task wait_lines(input int k);
      for (int t = 0; t < 3 * FR && ltpg_grabber_inst.lines < k; t++) @(posedge clk);
   endtask
   task run_line(input logic [2:0] p, input logic [1:0] d);
      logic [11:0] pv;
      logic [11:0] ev;
      if (p == 3'h2 && sel != 3'h2) mofs = 0;
      @(negedge clk);
      sel = p;
      dep = d;
      l0 = ltpg_grabber_inst.lines;
      ltpg_grabber_inst.pulse(1 + $urandom % 4, 1 + $urandom % 4);
      wait_lines(l0 + 1);
      check(16'(ltpg_grabber_inst.lines - l0), 16'h0001);
      for (int i = 0; i < LP; i++) begin
         pv = ltpg_grabber_inst.pix[i];
         ev = expv(p, d, i, mofs);
         if (p == 3'h1) check(16'(pv), 16'(ev));
         else if (p == 3'h2) check(16'(pv), 16'(ev));
         else if (p == 3'h3) check(16'(pv), 16'(ev));
         else check(16'(pv), 16'(ev));
      end
      if (p == 3'h2) mofs++;
      $display("line done pattern %0d depth %0d", p, d);
   endtask
   // op is write, read, begin, factory; one request cycle, answer seen next
   task shd(input logic [3:0] op, input logic [5:0] a, input logic [15:0] v);
      @(negedge clk);
      {swr, srd, sbeg, sfac} = op;
      sa = a;
      swd = v;
      @(negedge clk);
      {swr, srd, sbeg} = 3'h0;
   endtask
   initial begin
      void'($urandom(32'h4651));
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      for (int p = 1; p < 5; p++)
         for (int d = 0; d < 3; d++)
            repeat (p == 2 ? 2 : 1) run_line(3'(p), 2'(d));
      l0 = ltpg_grabber_inst.lines;
      ltpg_grabber_inst.pulse(1, 1);
      ltpg_grabber_inst.pulse(1, 1);
      repeat (3 * LP) @(posedge clk);
      check(16'(ltpg_grabber_inst.lines - l0), 16'h0002);
      @(negedge clk);
      sel = 3'h0;
      ltpg_grabber_inst.pulse(2, 2);
      repeat (2 * LP) @(posedge clk);
      check(16'(ltpg_grabber_inst.lines - l0), 16'h0002);
      repeat (8) begin
         @(negedge clk);
         check(16'({vdat, vdv, vlv}), 16'({sdat, sdv, slv}));
      end
      $display("trigger tests done");
      @(negedge clk);
      sel = 3'h4;
      ext = 1'b0;
      wait_lines(l0 + 3);
      t0 = cyc;
      wait_lines(l0 + 4);
      check(16'(cyc - t0), 16'(FR));
      check(16'(ltpg_grabber_inst.pix[7]), 16'(expv(3'h4, dep, 7, 0)));
      l0 = ltpg_grabber_inst.lines;
      @(negedge clk);
      ext = 1'b1;
      repeat (2 * LP) @(posedge clk);
      check(16'(ltpg_grabber_inst.lines - l0), 16'h0000);
      $display("free run done");
      wd = 16'($urandom);
      shd(4'b1000, 6'h3f, wd);
      shd(4'b0010, 6'h00, 16'h0000);
      shd(4'b1000, 6'h05, wd);
      shd(4'b0100, 6'h05, 16'h0000);
      check(rdat, wd);
      check(16'(srv), 16'h0001);
      shd(4'b0100, 6'h3f, 16'h0000);
      check(rdat, 16'h0000);
      shd(4'b1001, 6'h05, ~wd);
      check(16'(srej), 16'h0001);
      shd(4'b0011, 6'h00, 16'h0000);
      check(16'(srej), 16'h0001);
      shd(4'b0101, 6'h05, 16'h0000);
      check(rdat, FW);
      shd(4'b0100, 6'h05, 16'h0000);
      check(rdat, wd);
      $display("shading done");
      end_of_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule // test_line_camera_test_pattern_gen
`default_nettype wire
